// ### csb_pkg.sv
// Package of constants for the control switch bit bank.
// Assumes one 125 MHz clock; the processing interval tick is derived here.
package csb_pkg;

   localparam int NUM_SWITCHES_BASE = 8;
   localparam int NUM_SWITCHES      = 16;
   localparam int REG_W             = 32;
   localparam int ADDR_W            = 8;

   // Processing interval: a quarter cycle of a 60 Hz power system, in ns.
   localparam int INTERVAL_NS   = 4166667;
   localparam int CLK_PERIOD_NS = 8;
   localparam int INTERVAL_CYC  = INTERVAL_NS / CLK_PERIOD_NS;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_PANEL_CMD  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PANEL_CFG  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SERIAL_CMD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PANEL_BITS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SERIAL_BITS= 8'h10;
   localparam logic [ADDR_W-1:0] OFS_LATCH_BITS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h18;

   // Command word fields: index in [3:0], action in [5:4].
   localparam int CMD_IDX_LSB = 0;
   localparam int CMD_ACT_LSB = 4;

   localparam logic [1:0] ACT_OFF   = 2'h0;
   localparam logic [1:0] ACT_ON    = 2'h1;
   localparam logic [1:0] ACT_PULSE = 2'h2;

   // Factory default: switches 3 and 4 configured (bit index 2 and 3).
   localparam logic [15:0] PANEL_CFG_RESET = 16'h000C;

   typedef enum logic [2:0]
   {
      CSB_NV_IDLE  = 3'b001,
      CSB_NV_WRITE = 3'b010,
      CSB_NV_WAIT  = 3'b100
   } csb_nv_state_t;

endpackage : csb_pkg

// ### csb_interval_tick.sv
// Divider that produces the one-cycle processing interval enable.
// Assumes a free-running clock and asynchronous active-low reset.
`timescale 1ns/1ps
module csb_interval_tick
#(
   parameter int INTERVAL_CYC = csb_pkg::INTERVAL_CYC
)
(
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      tick
);

   localparam int CW = $clog2(INTERVAL_CYC);

   logic [CW-1:0] count_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count_reg <= '0;
         tick      <= 1'b0;
      end
      else if (count_reg == CW'(INTERVAL_CYC - 1))
      begin
         count_reg <= '0;
         tick      <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 1'b1;
         tick      <= 1'b0;
      end
   end

endmodule : csb_interval_tick

// ### csb_bank.sv
// Control switch bit bank: panel, serial and retained flip-flop bits behind AHB-Lite.
// Assumes hresetn models power restoration and that an external store holds retained bits.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps

// How it works
// - panel positions and switch settings take no reset, so they survive power loss.
// - setting and group changes leave panel bits untouched.
// - changes to an inactive group never stall panel bit evaluation.
// - unconfiguring a panel switch forces its bit to 0.
// - a newly configured panel switch starts at 0.
// - serial commands ON sets 1, OFF clears, PULSE is 1 one interval.
// - serial bits change only by serial command writes.
// - serial bits restart at 0 after power returns.
// - serial bits unchanged across setting or group changes.
// - inactive group changes never interrupt serial bits.
// - retained flip-flop bits are written to nonvolatile storage.
// - output drive of retained bits is low until restore completes.
// - sixteen retained flip-flops, eight enabled in base variant.
// - switch 3 defaults to pulse switch driving trip and lockout.
// - switch 4 defaults to pulse switch driving manual close.
// - panel pulse drives bit high one interval then back to 0.
// - set condition high drives retained bit to 1.
// - clear condition wins and drives retained bit to 0.
module csb_bank #(parameter int INTERVAL_CYC = csb_pkg::INTERVAL_CYC)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        extended_variant,
   input  wire logic        settings_change,
   input  wire logic        group_switch,
   input  wire logic [15:0] flipflop_set_condition,
   input  wire logic [15:0] flipflop_clear_condition,
   input  wire logic [15:0] nv_stored_bits,
   input  wire logic        nv_write_done,
   output logic [15:0]      nv_write_data,
   output logic             nv_write_commit,
   output logic [15:0]      panel_switch_bit,
   output logic [15:0]      serial_switch_bit,
   output logic [15:0]      retained_flipflop_bit,
   output logic [15:0]      retained_contact_drive,
   output logic             manual_trip_panel_bit,
   output logic             manual_close_panel_bit,
   output logic             trip_condition,
   output logic             manual_close_condition,
   output logic             reclose_lockout_condition,
   output logic             interval_tick
);

   ////////////////////////////////////////////////////////////////////////////
   // Interval enable.

   csb_interval_tick #(.INTERVAL_CYC(INTERVAL_CYC)) u_tick
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (interval_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY.

   logic        wr_pend_reg;
   logic [7:0]  addr_reg;
   logic        rd_pend_reg;
   logic        addr_phase;

   assign addr_phase = hsel && hready && htrans[1];
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= '0;
      end
      else
      begin
         wr_pend_reg <= addr_phase && hwrite;
         rd_pend_reg <= addr_phase && !hwrite;
         if (addr_phase)
            addr_reg <= haddr[7:0];
      end
   end

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = wr_pend_reg && (addr_reg == ofs);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////////
   // Pending commands held until the next interval boundary.

   logic        pcmd_valid_reg;
   logic [3:0]  pcmd_idx_reg;
   logic [1:0]  pcmd_act_reg;
   logic        scmd_valid_reg;
   logic [3:0]  scmd_idx_reg;
   logic [1:0]  scmd_act_reg;
   logic [15:0] panel_cfg_reg = csb_pkg::PANEL_CFG_RESET;
   logic [15:0] cfg_prev_reg  = csb_pkg::PANEL_CFG_RESET;

   // A write arriving on the tick is kept for the following boundary rather than lost.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pcmd_valid_reg <= 1'b0;
         pcmd_idx_reg   <= '0;
         pcmd_act_reg   <= '0;
         scmd_valid_reg <= 1'b0;
         scmd_idx_reg   <= '0;
         scmd_act_reg   <= '0;
      end
      else
      begin
         if (wr_hit(csb_pkg::OFS_PANEL_CMD))
         begin
            pcmd_valid_reg <= 1'b1;
            pcmd_idx_reg   <= hwdata[csb_pkg::CMD_IDX_LSB +: 4];
            pcmd_act_reg   <= hwdata[csb_pkg::CMD_ACT_LSB +: 2];
         end
         else if (interval_tick)
            pcmd_valid_reg <= 1'b0;
         if (wr_hit(csb_pkg::OFS_SERIAL_CMD))
         begin
            scmd_valid_reg <= 1'b1;
            scmd_idx_reg   <= hwdata[csb_pkg::CMD_IDX_LSB +: 4];
            scmd_act_reg   <= hwdata[csb_pkg::CMD_ACT_LSB +: 2];
         end
         else if (interval_tick)
            scmd_valid_reg <= 1'b0;
      end
   end

   // Settings sit in nonvolatile memory, so a power loss leaves the configuration alone.
   always_ff @(posedge hclk)
   begin
      if (wr_hit(csb_pkg::OFS_PANEL_CFG))
         panel_cfg_reg <= hwdata[15:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Panel bits: held state plus one-interval pulse.

   logic [15:0] panel_hold_reg = 16'h0000;
   logic [15:0] panel_pulse_reg;
   logic [15:0] enabled_mask;
   logic        pcmd_take;

   assign enabled_mask = extended_variant ? 16'hFFFF : 16'h00FF;
   assign pcmd_take    = pcmd_valid_reg && panel_cfg_reg[pcmd_idx_reg] && cfg_prev_reg[pcmd_idx_reg];

   // Settings and group changes are not inputs here, so no group change can disturb or stall the bits.
   // No reset here: like a switch on a panel, a held position rides through a power loss.
   always_ff @(posedge hclk)
   begin
      if (interval_tick)
      begin
         cfg_prev_reg   <= panel_cfg_reg;
         panel_hold_reg <= panel_hold_reg & panel_cfg_reg & cfg_prev_reg;
         if (pcmd_take)
         begin
            case (pcmd_act_reg)
               csb_pkg::ACT_ON:    panel_hold_reg[pcmd_idx_reg] <= 1'b1;
               csb_pkg::ACT_OFF:   panel_hold_reg[pcmd_idx_reg] <= 1'b0;
               csb_pkg::ACT_PULSE: panel_hold_reg[pcmd_idx_reg] <= 1'b0;
               default:            ;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         panel_pulse_reg <= '0;
      else if (interval_tick)
      begin
         panel_pulse_reg <= '0;
         if (pcmd_take && pcmd_act_reg == csb_pkg::ACT_PULSE)
            panel_pulse_reg[pcmd_idx_reg] <= 1'b1;
      end
   end

   always_comb
   begin
      panel_switch_bit = (panel_hold_reg | panel_pulse_reg) & panel_cfg_reg & enabled_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial bits.

   logic [15:0] serial_hold_reg;
   logic [15:0] serial_pulse_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         serial_hold_reg  <= '0;
         serial_pulse_reg <= '0;
      end
      else if (interval_tick)
      begin
         serial_pulse_reg <= '0;
         if (scmd_valid_reg)
         begin
            case (scmd_act_reg)
               csb_pkg::ACT_ON:    serial_hold_reg[scmd_idx_reg] <= 1'b1;
               csb_pkg::ACT_OFF:   serial_hold_reg[scmd_idx_reg] <= 1'b0;
               csb_pkg::ACT_PULSE:
               begin
                  serial_hold_reg[scmd_idx_reg]  <= 1'b0;
                  serial_pulse_reg[scmd_idx_reg] <= 1'b1;
               end
               default:            serial_pulse_reg <= '0;
            endcase
         end
      end
   end

   assign serial_switch_bit = (serial_hold_reg | serial_pulse_reg) & enabled_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Retained flip-flops and nonvolatile store.

   logic [15:0]          latch_reg;
   logic                 restored_reg;
   csb_pkg::csb_nv_state_t nv_state_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         latch_reg    <= '0;
         restored_reg <= 1'b0;
      end
      else if (!restored_reg)
      begin
         latch_reg    <= nv_stored_bits;
         restored_reg <= 1'b1;
      end
      else if (interval_tick)
         latch_reg <= (latch_reg | flipflop_set_condition) & ~flipflop_clear_condition
                      & enabled_mask;
   end

   assign retained_flipflop_bit  = latch_reg;
   assign retained_contact_drive = restored_reg ? latch_reg : 16'h0000;

   // Whole word committed with one strobe so the store keeps either old or new.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nv_state_reg    <= csb_pkg::CSB_NV_IDLE;
         nv_write_data   <= '0;
         nv_write_commit <= 1'b0;
      end
      else
      begin
         nv_write_commit <= 1'b0;
         case (nv_state_reg)
            csb_pkg::CSB_NV_IDLE:
               if (restored_reg && latch_reg != nv_write_data)
               begin
                  nv_write_data <= latch_reg;
                  nv_state_reg  <= csb_pkg::CSB_NV_WRITE;
               end
            csb_pkg::CSB_NV_WRITE:
            begin
               nv_write_commit <= 1'b1;
               nv_state_reg    <= csb_pkg::CSB_NV_WAIT;
            end
            csb_pkg::CSB_NV_WAIT:
               if (nv_write_done)
                  nv_state_reg <= csb_pkg::CSB_NV_IDLE;
            default:
               nv_state_reg <= csb_pkg::CSB_NV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Factory default uses of switches 3 and 4.

   assign manual_trip_panel_bit     = panel_switch_bit[2];
   assign manual_close_panel_bit    = panel_switch_bit[3];
   assign trip_condition            = manual_trip_panel_bit;
   assign reclose_lockout_condition = manual_trip_panel_bit;
   assign manual_close_condition    = manual_close_panel_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= '0;
      else if (addr_phase && !hwrite)
      begin
         case (haddr[7:0])
            csb_pkg::OFS_PANEL_CFG:   hrdata <= {16'h0000, panel_cfg_reg};
            csb_pkg::OFS_PANEL_BITS:  hrdata <= {16'h0000, panel_switch_bit};
            csb_pkg::OFS_SERIAL_BITS: hrdata <= {16'h0000, serial_switch_bit};
            csb_pkg::OFS_LATCH_BITS:  hrdata <= {16'h0000, latch_reg};
            csb_pkg::OFS_STATUS:      hrdata <= {29'h0, restored_reg, pcmd_valid_reg, scmd_valid_reg};
            default:                  hrdata <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence pulse_cmd_s;
      interval_tick && scmd_valid_reg && scmd_act_reg == csb_pkg::ACT_PULSE;
   endsequence
   serial_pulse_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pulse_cmd_s |=> serial_hold_reg[$past(scmd_idx_reg)] == 1'b0 && serial_pulse_reg != 16'h0000)
      else $error("serial pulse not raised");
   serial_pulse_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
      interval_tick && serial_pulse_reg != 16'h0000 |=> serial_pulse_reg == 16'h0000)
      else $error("serial pulse too long");
   serial_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
      interval_tick && scmd_valid_reg && scmd_act_reg == csb_pkg::ACT_ON |=> serial_hold_reg[$past(scmd_idx_reg)])
      else $error("serial on not applied");
   serial_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !interval_tick |=> $stable(serial_hold_reg))
      else $error("serial bit changed off boundary");
   panel_unconf_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (panel_switch_bit & ~panel_cfg_reg) == 16'h0000)
      else $error("unconfigured panel bit high");
   panel_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      interval_tick && panel_pulse_reg != 16'h0000 |=> panel_pulse_reg == 16'h0000)
      else $error("panel pulse too long");
   latch_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      restored_reg && interval_tick && flipflop_clear_condition != 16'h0000
      |=> (latch_reg & $past(flipflop_clear_condition)) == 16'h0000)
      else $error("clear did not win");
   latch_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      restored_reg && interval_tick && flipflop_set_condition[0] && !flipflop_clear_condition[0]
      |=> latch_reg[0])
      else $error("set not applied");
   contact_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !restored_reg |-> retained_contact_drive == 16'h0000)
      else $error("contact driven before restore");
   nv_commit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      nv_write_commit |-> $stable(nv_write_data))
      else $error("store data moved at commit");

endmodule : csb_bank

// ### csb_nv_store_model.sv
// Behavioural nonvolatile store that backs the retained flip-flop bits of the bank.
// Assumes commit pulses from the bank; the contents ignore hresetn, as a power loss would.
`timescale 1ns/1ps
module csb_nv_store_model
#(
   parameter logic [15:0] INIT_BITS = 16'h0004,
   parameter int          DONE_DLY  = 3
)
(
   input  wire logic        hclk,
   input  wire logic [15:0] nv_write_data,
   input  wire logic        nv_write_commit,
   output logic [15:0]      nv_stored_bits,
   output logic             nv_write_done
);
   logic [15:0] store_reg = INIT_BITS;
   logic [15:0] pend_reg  = 16'h0000;
   logic        done_reg  = 1'b0;
   int          cnt       = 0;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // The word is taken whole at commit and replaces the old one only when the write ends, so a
   // supply loss in between leaves the old value intact.
   always @(posedge hclk)
   begin
      done_reg <= 1'b0;
      if (nv_write_commit === 1'b1)
      begin
         pend_reg <= nv_write_data;
         cnt      <= DONE_DLY;
      end
      else if (cnt > 1)
      begin
         cnt <= cnt - 1;
      end
      else if (cnt == 1)
      begin
         cnt           <= 0;
         store_reg     <= pend_reg;
         done_reg      <= 1'b1;
      end
   end

   assign nv_stored_bits = store_reg;
   assign nv_write_done  = done_reg;
endmodule : csb_nv_store_model

// ### tb.sv
// Self-checking bench for the control switch bit bank, driven over AHB-Lite.
// Overrides the quarter-cycle interval with a 200-clock one; a run therefore spans a few intervals.
`timescale 1ns/1ps
module tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        ext_var;
   logic        set_chg;
   logic        grp_sw;
   logic [15:0] ff_set;
   logic [15:0] ff_clr;
   logic [15:0] nv_bits;
   logic        nv_done;
   logic [15:0] nv_data;
   logic        nv_commit;
   logic [15:0] pbit;
   logic [15:0] sbit;
   logic [15:0] lbit;
   logic [15:0] drive;
   logic        mtrip;
   logic        mclose;
   logic        trip_c;
   logic        close_c;
   logic        lock_c;
   logic        tick;
   int          n_errors     = 0;
   int          total_checks = 0;

   // A short interval keeps the run brief; the real one is over half a million clocks.
   csb_bank #(.INTERVAL_CYC(200)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .extended_variant(ext_var), .settings_change(set_chg),
      .group_switch(grp_sw), .flipflop_set_condition(ff_set), .flipflop_clear_condition(ff_clr),
      .nv_stored_bits(nv_bits), .nv_write_done(nv_done), .nv_write_data(nv_data),
      .nv_write_commit(nv_commit), .panel_switch_bit(pbit), .serial_switch_bit(sbit),
      .retained_flipflop_bit(lbit), .retained_contact_drive(drive), .manual_trip_panel_bit(mtrip),
      .manual_close_panel_bit(mclose), .trip_condition(trip_c), .manual_close_condition(close_c),
      .reclose_lockout_condition(lock_c), .interval_tick(tick));

   csb_nv_store_model NV (.hclk(hclk), .nv_write_data(nv_data), .nv_write_commit(nv_commit),
      .nv_stored_bits(nv_bits), .nv_write_done(nv_done));

   initial hclk = 1'b0;
   always #4 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Waits one edge at a time for hready; a stuck slave ends the run.
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64)
      begin
         n_errors++;
         print_verdict();
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      wait_ready();
      d = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, ofs, wd, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, ofs, 32'h00000000, d);
      check(d, exp);
   endtask : rd_chk

   // Commands land at the tick edge, so outputs are looked at one edge later.
   task automatic wait_tick;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (tick !== 1'b1 && n < 1000);
      if (n >= 1000)
      begin
         n_errors++;
         print_verdict();
      end
      @(posedge hclk);
   endtask : wait_tick

   task automatic power_cycle;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      check({16'h0000, drive}, 32'h00000000);
      check({31'h0, hreadyout}, 32'h00000001);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask : power_cycle

   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hsel    = 1'b0;
      haddr   = 32'h00000000;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h00000000;
      ext_var = 1'b1;
      set_chg = 1'b0;
      grp_sw  = 1'b0;
      ff_set  = 16'h0000;
      ff_clr  = 16'h0000;
      power_cycle();
      check({16'h0000, lbit}, 32'h00000004);
      check({16'h0000, drive}, 32'h00000004);
      check({31'h0, hresp}, 32'h00000000);
      rd_chk(csb_pkg::OFS_PANEL_CFG, 32'h0000000C);
      rd_chk(csb_pkg::OFS_SERIAL_BITS, 32'h00000000);
      rd_chk(8'h1C, 32'h00000000);
      wr(csb_pkg::OFS_PANEL_CFG, 32'h0000000D);
      wr(csb_pkg::OFS_PANEL_CMD, 32'h00000022);
      wr(csb_pkg::OFS_SERIAL_CMD, 32'h00000015);
      ext_var <= 1'b0;
      set_chg <= 1'b1;
      grp_sw  <= 1'b1;
      ff_set  <= 16'h0203;
      ff_clr  <= 16'h0006;
      rd_chk(csb_pkg::OFS_STATUS, 32'h00000007);
      rd_chk(csb_pkg::OFS_PANEL_BITS, 32'h00000000);
      wait_tick();
      check({16'h0000, pbit}, 32'h00000004);
      check({29'h0, mtrip, trip_c, lock_c}, 32'h00000007);
      check({16'h0000, sbit}, 32'h00000020);
      check({16'h0000, lbit}, 32'h00000001);
      check({16'h0000, drive}, 32'h00000001);
      ext_var <= 1'b1;
      set_chg <= 1'b0;
      grp_sw  <= 1'b0;
      ff_set  <= 16'h0000;
      ff_clr  <= 16'h0000;
      wr(csb_pkg::OFS_PANEL_CMD, 32'h00000010);
      wr(csb_pkg::OFS_SERIAL_CMD, 32'h00000027);
      wait_tick();
      check({16'h0000, pbit}, 32'h00000001);
      check({16'h0000, sbit}, 32'h000000A0);
      check({16'h0000, nv_bits}, 32'h00000001);
      wr(csb_pkg::OFS_PANEL_CFG, 32'h0000000C);
      wr(csb_pkg::OFS_PANEL_CMD, 32'h00000023);
      wait_tick();
      check({16'h0000, pbit}, 32'h00000008);
      check({30'h0, mclose, close_c}, 32'h00000003);
      rd_chk(csb_pkg::OFS_SERIAL_BITS, 32'h00000020);
      power_cycle();
      check({16'h0000, sbit}, 32'h00000000);
      check({16'h0000, lbit}, 32'h00000001);
      check({16'h0000, drive}, 32'h00000001);
      rd_chk(csb_pkg::OFS_LATCH_BITS, 32'h00000001);
      wr(csb_pkg::OFS_PANEL_CMD, 32'h00000013);
      wait_tick();
      check({16'h0000, pbit}, 32'h00000008);
      power_cycle();
      check({16'h0000, pbit}, 32'h00000008);
      rd_chk(csb_pkg::OFS_PANEL_BITS, 32'h00000008);
      print_verdict();
   end
endmodule : tb
